// ### rtl/rsse_consts.svh
// Constants for the rotate, subtract and sleep execution block.
// Assumes inclusion by the core, the checker and the bench only.
`ifndef RSSE_CONSTS_SVH
`define RSSE_CONSTS_SVH

// ****************************************************************
// Register port map
// ****************************************************************
`define RSSE_FILE_LAST_ADDR   8'h7F
`define RSSE_WORK_ADDR        8'h80
`define RSSE_STATUS_ADDR      8'h81
`define RSSE_WDOG_ADDR        8'h82
`define RSSE_PRESCALE_ADDR    8'h83

// ****************************************************************
// Status field positions and reset value
// ****************************************************************
`define RSSE_ST_CARRY         0
`define RSSE_ST_DIGIT         1
`define RSSE_ST_ZERO          2
`define RSSE_ST_PD_N          3
`define RSSE_ST_TO_N          4
`define RSSE_STATUS_RESET     8'h18
`define RSSE_STATUS_WR_MASK   8'h07

// ****************************************************************
// Watchdog
// ****************************************************************
`define RSSE_WDOG_CLEAR       8'h00
`define RSSE_PRESCALE_CLEAR   8'h00
`define RSSE_PRESCALE_LAST    8'hFF

`endif

// ### rtl/rsse_pkg.sv
// Types for the rotate, subtract and sleep execution block.
// Assumes the constants header sits beside it.
package rsse_pkg;

	typedef enum logic [2:0]
	{
		RSSE_OP_NONE  = 3'h0,
		RSSE_OP_ROTL  = 3'h1,
		RSSE_OP_ROTR  = 3'h2,
		RSSE_OP_SUB   = 3'h3,
		RSSE_OP_SLEEP = 3'h4
	} rsse_op_type;

	typedef enum logic [0:0]
	{
		RSSE_RUN   = 1'h0,
		RSSE_ASLEEP = 1'h1
	} rsse_state_type;

endpackage : rsse_pkg

// ### rtl/rsse_alu_if.sv
// Operand and result bundle between the core and its arithmetic unit.
// Assumes both ends run combinationally within one clock cycle.
`timescale 1ns/100ps

interface rsse_alu_if;
	import rsse_pkg::*;

	rsse_op_type op;
	logic [7:0]  file_val;
	logic [7:0]  work_val;
	logic [7:0]  literal;
	logic        carry_in;
	logic [7:0]  result;
	logic        carry_out;
	logic        digit_out;
	logic        zero_out;

	modport core
	(
		output op,
		output file_val,
		output work_val,
		output literal,
		output carry_in,
		input  result,
		input  carry_out,
		input  digit_out,
		input  zero_out
	);

	modport alu
	(
		input  op,
		input  file_val,
		input  work_val,
		input  literal,
		input  carry_in,
		output result,
		output carry_out,
		output digit_out,
		output zero_out
	);

endinterface : rsse_alu_if

// ### rtl/rsse_alu.sv
// Combinational arithmetic for the two rotates and literal subtract.
// Assumes the core decides which flags and destination take the result.
`timescale 1ns/100ps

module rsse_alu
	import rsse_pkg::*;
(
	// Operands and results
	rsse_alu_if.alu bus
);

	logic [8:0] diff;
	logic [4:0] nib_diff;

	always_comb
	begin
		diff      = {1'b0, bus.literal} - {1'b0, bus.work_val};
		nib_diff  = {1'b0, bus.literal[3:0]} - {1'b0, bus.work_val[3:0]};
		bus.result    = bus.file_val;
		bus.carry_out = bus.carry_in;
		bus.digit_out = 1'b0;
		bus.zero_out  = 1'b0;
		case (bus.op)
			RSSE_OP_ROTL:
			begin
				bus.result    = {bus.file_val[6:0], bus.carry_in}; // [RULE_01]
				bus.carry_out = bus.file_val[7]; // [RULE_01]
			end
			RSSE_OP_ROTR:
			begin
				bus.result    = {bus.carry_in, bus.file_val[7:1]}; // [RULE_03]
				bus.carry_out = bus.file_val[0]; // [RULE_03]
			end
			RSSE_OP_SUB:
			begin
				// A borrow out of bit 8 means the work value exceeded the literal.
				bus.result    = diff[7:0]; // [RULE_09]
				bus.carry_out = ~diff[8]; // [RULE_10]
				bus.digit_out = ~nib_diff[4]; // [RULE_10]
				bus.zero_out  = (diff[7:0] == 8'h00); // [RULE_10]
			end
			default:
			begin
				bus.result = bus.file_val;
			end
		endcase
	end

endmodule : rsse_alu

// ### rtl/rsse_core.sv
// Execution core for rotates through carry, literal subtract and sleep.
// Assumes instructions arrive decoded, one per clock, from fetch logic on clk.
// The wake input is asynchronous and is synchronised here.
//
// Behaviour
// RULE_01: Rotate left moves carry in, bit 7 out.
// RULE_02: Rotate left: 7-bit address, destination bit selects target.
// RULE_03: Rotate right moves carry in, bit 0 out.
// RULE_04: Rotate right: destination bit selects work or file.
// RULE_05: Sleep clears power-down flag, arithmetic flags untouched.
// RULE_06: Sleep sets the time-out flag.
// RULE_07: Sleep zeroes watchdog counter and its prescaler.
// RULE_08: Sleep then halts oscillator; no more instructions.
// RULE_09: Subtract computes literal minus work into work.
// RULE_10: Subtract updates carry, digit carry, zero.
// RULE_11: Rotates and subtract finish in one cycle.
//
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
`include "rsse_consts.svh"

module rsse_core
	import rsse_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Decoded instruction
	input  wire logic        instr_valid,
	input  rsse_op_type      instr_op,
	input  wire logic [6:0]  instr_file_addr,
	input  wire logic        instr_dest,
	input  wire logic [7:0]  instr_literal,
	// Wake request pin
	input  wire logic        wake_pin,
	// Power state
	output logic             osc_stop,
	output logic             instr_ready,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [7:0]       reg_rdata
);

	// ****************************************************************
	// State
	// ****************************************************************
	logic [7:0]     file_mem [0:127];
	logic [7:0]     work_q;
	logic [7:0]     status_word;
	logic           carry_q;
	logic           digit_q;
	logic           zero_q;
	logic           pd_n_q;
	logic           to_n_q;
	logic           status_wr;
	logic [7:0]     wdog_q;
	logic [7:0]     prescale_q;
	logic [7:0]     rdata_q;
	rsse_state_type state_q;
	rsse_state_type state_d;
	logic           wake_meta_q;
	logic           wake_sync_q;

	rsse_alu_if alu_bus ();

	// ****************************************************************
	// Decode
	// ****************************************************************
	logic       exec;
	logic       is_rot;
	logic       is_sub;
	logic       is_sleep;
	logic       to_file;
	logic       to_work;
	logic [7:0] file_rd;

	assign instr_ready = (state_q == RSSE_RUN);
	// An asleep core ignores instructions: the oscillator is stopped.
	assign exec     = instr_valid && (state_q == RSSE_RUN); // [RULE_08]
	assign is_rot   = exec && ((instr_op == RSSE_OP_ROTL) || (instr_op == RSSE_OP_ROTR));
	assign is_sub   = exec && (instr_op == RSSE_OP_SUB);
	assign is_sleep = exec && (instr_op == RSSE_OP_SLEEP);
	assign to_file  = is_rot && instr_dest; // [RULE_02] [RULE_04]
	assign to_work  = (is_rot && !instr_dest) || is_sub; // [RULE_02] [RULE_04] [RULE_09]
	assign file_rd  = file_mem[instr_file_addr]; // [RULE_02]

	// ****************************************************************
	// Arithmetic unit
	// ****************************************************************
	assign alu_bus.op       = exec ? instr_op : RSSE_OP_NONE;
	assign alu_bus.file_val = file_rd;
	assign alu_bus.work_val = work_q;
	assign alu_bus.literal  = instr_literal;
	assign alu_bus.carry_in = carry_q;

	rsse_alu u_alu
	(
		.bus (alu_bus.alu)
	);

	// ****************************************************************
	// Wake synchroniser
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			wake_meta_q <= 1'b0;
			wake_sync_q <= 1'b0;
		end
		else
		begin
			wake_meta_q <= wake_pin;
			wake_sync_q <= wake_meta_q;
		end
	end

	// ****************************************************************
	// Power state
	// ****************************************************************
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			RSSE_RUN:
			begin
				if (is_sleep)
				begin
					state_d = RSSE_ASLEEP; // [RULE_08]
				end
			end
			RSSE_ASLEEP:
			begin
				if (wake_sync_q)
				begin
					state_d = RSSE_RUN;
				end
			end
			default:
			begin
				state_d = RSSE_RUN;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state_q <= RSSE_RUN;
		end
		else
		begin
			state_q <= state_d;
		end
	end

	assign osc_stop = (state_q == RSSE_ASLEEP); // [RULE_08]

	// ****************************************************************
	// File registers
	// ****************************************************************
	// No reset: the file is plain storage. An instruction write wins over a
	// port write to the same cycle, so the port write is dropped then.
	always_ff @(posedge clk)
	begin
		if (to_file)
		begin
			file_mem[instr_file_addr] <= alu_bus.result; // [RULE_02] [RULE_04] [RULE_11]
		end
		else if (reg_wr && (reg_addr <= `RSSE_FILE_LAST_ADDR))
		begin
			file_mem[reg_addr[6:0]] <= reg_wdata;
		end
	end

	// ****************************************************************
	// Work register
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			work_q <= 8'h00;
		end
		else if (to_work)
		begin
			work_q <= alu_bus.result; // [RULE_02] [RULE_04] [RULE_09] [RULE_11]
		end
		else if (reg_wr && (reg_addr == `RSSE_WORK_ADDR))
		begin
			work_q <= reg_wdata;
		end
	end

	// ****************************************************************
	// Status flags
	// ****************************************************************
	// One register per flag keeps each flag's sources in one place. A rotate,
	// subtract or sleep executed in the same cycle drops a port write to the whole status
	// word, so software never sees half of its write land.
	localparam logic [7:0] STATUS_INIT    = `RSSE_STATUS_RESET;
	localparam logic [7:0] STATUS_WR_MASK = `RSSE_STATUS_WR_MASK;

	assign status_wr = reg_wr && (reg_addr == `RSSE_STATUS_ADDR)
		&& !(is_rot || is_sub || is_sleep);

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			carry_q <= STATUS_INIT[`RSSE_ST_CARRY];
		end
		else if (is_rot || is_sub)
		begin
			carry_q <= alu_bus.carry_out; // [RULE_01] [RULE_03] [RULE_10]
		end
		else if (status_wr && STATUS_WR_MASK[`RSSE_ST_CARRY])
		begin
			carry_q <= reg_wdata[`RSSE_ST_CARRY];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			digit_q <= STATUS_INIT[`RSSE_ST_DIGIT];
		end
		else if (is_sub)
		begin
			digit_q <= alu_bus.digit_out; // [RULE_10]
		end
		else if (status_wr && STATUS_WR_MASK[`RSSE_ST_DIGIT])
		begin
			digit_q <= reg_wdata[`RSSE_ST_DIGIT];
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			zero_q <= STATUS_INIT[`RSSE_ST_ZERO];
		end
		else if (is_sub)
		begin
			zero_q <= alu_bus.zero_out; // [RULE_10]
		end
		else if (status_wr && STATUS_WR_MASK[`RSSE_ST_ZERO])
		begin
			zero_q <= reg_wdata[`RSSE_ST_ZERO];
		end
	end

	// Sleep touches only the two power flags below, never the arithmetic ones.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			pd_n_q <= STATUS_INIT[`RSSE_ST_PD_N];
		end
		else if (is_sleep)
		begin
			pd_n_q <= 1'b0; // [RULE_05]
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			to_n_q <= STATUS_INIT[`RSSE_ST_TO_N];
		end
		else if (is_sleep)
		begin
			to_n_q <= 1'b1; // [RULE_06]
		end
	end

	// Bits without a flag read as zero.
	always_comb
	begin
		status_word                 = 8'h00;
		status_word[`RSSE_ST_CARRY] = carry_q;
		status_word[`RSSE_ST_DIGIT] = digit_q;
		status_word[`RSSE_ST_ZERO]  = zero_q;
		status_word[`RSSE_ST_PD_N]  = pd_n_q;
		status_word[`RSSE_ST_TO_N]  = to_n_q;
	end

	// ****************************************************************
	// Watchdog counter and prescaler
	// ****************************************************************
	// Both stand still while asleep, since they count only while state_q is RSSE_RUN.
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			prescale_q <= `RSSE_PRESCALE_CLEAR;
			wdog_q     <= `RSSE_WDOG_CLEAR;
		end
		else if (is_sleep)
		begin
			prescale_q <= `RSSE_PRESCALE_CLEAR; // [RULE_07]
			wdog_q     <= `RSSE_WDOG_CLEAR; // [RULE_07]
		end
		else if (state_q == RSSE_RUN)
		begin
			prescale_q <= prescale_q + 8'h01;
			if (prescale_q == `RSSE_PRESCALE_LAST)
			begin
				wdog_q <= wdog_q + 8'h01;
			end
		end
	end

	// ****************************************************************
	// Register read port
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			rdata_q <= 8'h00;
		end
		else if (reg_rd)
		begin
			if (reg_addr <= `RSSE_FILE_LAST_ADDR)
			begin
				rdata_q <= file_mem[reg_addr[6:0]];
			end
			else
			begin
				case (reg_addr)
					`RSSE_WORK_ADDR:     rdata_q <= work_q;
					`RSSE_STATUS_ADDR:   rdata_q <= status_word;
					`RSSE_WDOG_ADDR:     rdata_q <= wdog_q;
					`RSSE_PRESCALE_ADDR: rdata_q <= prescale_q;
					default:             rdata_q <= 8'h00;
				endcase
			end
		end
		else
		begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : rsse_core

// ### sim/rsse_core_chk.sv
// Port-side checker for the rotate, subtract and sleep core.
// Assumes one clock domain with synchronous active-high reset.
`timescale 1ns/100ps
`include "rsse_consts.svh"

module rsse_core_chk
	import rsse_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        srst,
	// Instruction side
	input  wire logic        instr_valid,
	input  rsse_op_type      instr_op,
	input  wire logic        wake_pin,
	input  wire logic        osc_stop,
	input  wire logic        instr_ready,
	// Register port
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_rdata
);
	// ****
	// Assertions
	// ****
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);

	logic take;
	logic rd_asleep;
	assign take      = instr_valid && instr_ready;
	assign rd_asleep = reg_rd && osc_stop;

	a_sleep_halts_core: assert property (
		take && instr_op == RSSE_OP_SLEEP |=> osc_stop && !instr_ready)
		else $error("sleep did not halt the core");
	a_halt_needs_sleep: assert property (
		$fell(instr_ready) |-> $past(take) && $past(instr_op) == RSSE_OP_SLEEP)
		else $error("core halted without a sleep instruction");
	// Three quiet wake samples cover the two-flop synchroniser and the state edge.
	a_asleep_stays_put: assert property (
		osc_stop && !wake_pin && !$past(wake_pin) && !$past(wake_pin, 2) |=> osc_stop)
		else $error("left sleep without a wake request");
	a_single_cycle_op: assert property (
		take && instr_op inside {RSSE_OP_ROTL, RSSE_OP_ROTR, RSSE_OP_SUB} |=> instr_ready)
		else $error("rotate or subtract did not finish in one cycle");
	a_powerdown_flag_clear: assert property (
		rd_asleep && reg_addr == `RSSE_STATUS_ADDR |=> !reg_rdata[`RSSE_ST_PD_N])
		else $error("power-down flag not clear while asleep");
	a_timeout_flag_set: assert property (
		rd_asleep && reg_addr == `RSSE_STATUS_ADDR |=> reg_rdata[`RSSE_ST_TO_N])
		else $error("time-out flag not set while asleep");
	a_watchdog_zero_asleep: assert property (
		rd_asleep && reg_addr == `RSSE_WDOG_ADDR |=> reg_rdata == `RSSE_WDOG_CLEAR)
		else $error("watchdog not cleared by sleep");
	a_prescale_zero_asleep: assert property (
		rd_asleep && reg_addr == `RSSE_PRESCALE_ADDR |=> reg_rdata == `RSSE_PRESCALE_CLEAR)
		else $error("prescaler not cleared by sleep");

	c_sleep: cover property (take && instr_op == RSSE_OP_SLEEP);
	c_sub: cover property (take && instr_op == RSSE_OP_SUB);
	c_wake: cover property ($fell(osc_stop));
endmodule : rsse_core_chk

bind rsse_core rsse_core_chk u_chk (.clk, .srst, .instr_valid, .instr_op, .wake_pin, .osc_stop,
	.instr_ready, .reg_addr, .reg_rd, .reg_rdata);

// ### sim/rsse_core_tb.sv
// Self-checking bench for the rotate, subtract and sleep core.
// Assumes the register map and status layout of the constants header.
`timescale 1ns/100ps
`include "rsse_consts.svh"

module rsse_core_tb
	import rsse_pkg::*;
;
	logic        clk;
	logic        srst;
	logic        instr_valid;
	rsse_op_type instr_op;
	logic [6:0]  instr_file_addr;
	logic        instr_dest;
	logic [7:0]  instr_literal;
	logic        wake_pin;
	logic        osc_stop;
	logic        instr_ready;
	logic [7:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic [7:0]  w;
	logic [7:0]  st;
	logic [7:0]  sw [4] = '{8'h01, 8'h02, 8'h0F, 8'h00};
	logic [7:0]  sk [4] = '{8'h01, 8'h01, 8'h10, 8'hFF};
	int          failures;
	int          total_checks;

	rsse_core dut (.clk, .srst, .instr_valid, .instr_op, .instr_file_addr, .instr_dest,
		.instr_literal, .wake_pin, .osc_stop, .instr_ready, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata);

	// ****
	// Tasks
	// ****
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd

	task automatic ex(input rsse_op_type op, input logic [6:0] a, input logic d,
		input logic [7:0] k);
		@(posedge clk);
		instr_valid     <= 1'b1;
		instr_op        <= op;
		instr_file_addr <= a;
		instr_dest      <= d;
		instr_literal   <= k;
		@(posedge clk);
		instr_valid <= 1'b0;
	endtask : ex

	task automatic give_verdict();
		$display("Checks %0d, failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : give_verdict

	// ****
	// Clock, watchdog and tests
	// ****
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial
	begin
		repeat (5000) @(posedge clk);
		failures++;
		give_verdict();
	end

	initial
	begin
		srst = 1'b1;
		{instr_valid, instr_dest, wake_pin, reg_wr, reg_rd} = 5'h00;
		instr_op = RSSE_OP_NONE;
		{instr_file_addr, instr_literal, reg_addr, reg_wdata} = 31'h0;
		failures = 0;
		total_checks = 0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(`RSSE_STATUS_ADDR, `RSSE_STATUS_RESET);
		rd(8'h90, 8'h00);
		wr(8'h05, 8'hE6);
		ex(RSSE_OP_ROTL, 7'h05, 1'b0, 8'h00);
		rd(`RSSE_WORK_ADDR, 8'hCC);
		rd(`RSSE_STATUS_ADDR, 8'h19);
		rd(8'h05, 8'hE6);
		wr(8'h7F, 8'h55);
		ex(RSSE_OP_ROTL, 7'h7F, 1'b1, 8'h00);
		rd(8'h7F, 8'hAB);
		rd(`RSSE_WORK_ADDR, 8'hCC);
		rd(`RSSE_STATUS_ADDR, 8'h18);
		wr(8'h00, 8'h81);
		ex(RSSE_OP_ROTR, 7'h00, 1'b0, 8'h00);
		rd(`RSSE_WORK_ADDR, 8'h40);
		rd(`RSSE_STATUS_ADDR, 8'h19);
		ex(RSSE_OP_ROTR, 7'h00, 1'b1, 8'h00);
		rd(8'h00, 8'hC0);
		rd(`RSSE_WORK_ADDR, 8'h40);
		for (int i = 0; i < 4; i++)
		begin
			wr(`RSSE_WORK_ADDR, sw[i]);
			ex(RSSE_OP_SUB, 7'h00, 1'b0, sk[i]);
			w = sk[i] - sw[i];
			rd(`RSSE_WORK_ADDR, w);
			st = {5'h03, w == 8'h00, sw[i][3:0] <= sk[i][3:0], sw[i] <= sk[i]};
			rd(`RSSE_STATUS_ADDR, st);
		end
		// Let the watchdog and prescaler count away from zero first.
		repeat (300) @(posedge clk);
		ex(RSSE_OP_SLEEP, 7'h00, 1'b0, 8'h00);
		#1;
		chk({7'h00, osc_stop}, 8'h01);
		rd(`RSSE_STATUS_ADDR, 8'h13);
		rd(`RSSE_WDOG_ADDR, `RSSE_WDOG_CLEAR);
		rd(`RSSE_PRESCALE_ADDR, `RSSE_PRESCALE_CLEAR);
		ex(RSSE_OP_ROTL, 7'h00, 1'b0, 8'h00);
		rd(`RSSE_WORK_ADDR, 8'hFF);
		@(posedge clk);
		wake_pin <= 1'b1;
		// Sample after each edge has settled, so the exit test never races the state flop.
		for (int n = 0; n < 8 && osc_stop; n++)
		begin
			@(posedge clk);
			#1;
		end
		chk({7'h00, osc_stop}, 8'h00);
		@(posedge clk);
		wake_pin <= 1'b0;
		ex(RSSE_OP_ROTR, 7'h00, 1'b0, 8'h00);
		rd(`RSSE_WORK_ADDR, 8'hE0);
		give_verdict();
	end
endmodule : rsse_core_tb
